/* hw/csu_pkg.sv */
// shared constants and types for the cluster semaphore unit
package csu_pkg;
	localparam int NUM_CPU = 4;
	localparam int CPU_W = 2;
	localparam int NUM_CLUSTER = 18;
	localparam int CLN_W = 5;
	localparam int SEM_COUNT = 64;
	localparam int SEM_W = 6;
	localparam int IMM_W = 5;
	localparam logic [SEM_W-1:0] SEM_UPPER_BASE = 6'h20;
	localparam int DEADLOCK_COUNT = 256;
	localparam int DL_W = 8;
	localparam logic [CLN_W-1:0] CLN_RESET = 5'h00;
	localparam logic [SEM_COUNT-1:0] SEM_RESET = 64'h0000000000000000;
	localparam logic [DL_W-1:0] DL_LAST = 8'(DEADLOCK_COUNT - 1);
	typedef enum logic [3:0] {
		CSU_OP_SET,
		CSU_OP_CLR,
		CSU_OP_TAS,
		CSU_OP_TASB,
		CSU_OP_RDALL,
		CSU_OP_WRALL,
		CSU_OP_XCHG,
		CSU_OP_CLN,
		CSU_OP_BCD
	} csu_op_t;
	// flag number from selector bit, immediate field and address register
	function automatic logic [SEM_W-1:0] csu_sem_index(input logic sel, input logic [IMM_W-1:0] imm,
			input logic [IMM_W-1:0] areg);
		csu_sem_index = sel ? (SEM_UPPER_BASE | {1'b0, areg}) : {1'b0, imm};
	endfunction : csu_sem_index
endpackage : csu_pkg

/* hw/csu_if.sv */
// command channel between the processor cores and the semaphore unit
`timescale 1ns/100ps
interface csu_if;
	import csu_pkg::*;
	logic cmd_valid;
	logic cmd_ready;
	logic [CPU_W-1:0] cmd_cpu;
	csu_op_t cmd_op;
	logic cmd_sel;
	logic [IMM_W-1:0] cmd_imm;
	logic [IMM_W-1:0] cmd_areg;
	logic [CLN_W-1:0] cmd_cln;
	logic cmd_user;
	logic [SEM_COUNT-1:0] cmd_data;
	logic rsp_valid;
	logic [CPU_W-1:0] rsp_cpu;
	logic rsp_branch;
	logic rsp_hold;
	logic [SEM_COUNT-1:0] rsp_data;
	logic [NUM_CPU-1:0] release_cpu;
	logic [NUM_CPU-1:0] deadlock_cpu;
	modport unit (input cmd_valid, cmd_cpu, cmd_op, cmd_sel, cmd_imm, cmd_areg, cmd_cln, cmd_user, cmd_data,
		output cmd_ready, rsp_valid, rsp_cpu, rsp_branch, rsp_hold, rsp_data, release_cpu, deadlock_cpu);
	modport core (output cmd_valid, cmd_cpu, cmd_op, cmd_sel, cmd_imm, cmd_areg, cmd_cln, cmd_user, cmd_data,
		input cmd_ready, rsp_valid, rsp_cpu, rsp_branch, rsp_hold, rsp_data, release_cpu, deadlock_cpu);
endinterface : csu_if

/* hw/csu_unit.sv */
// semaphore, attachment and deadlock logic of the shared register module
`timescale 1ns/100ps
module csu_unit (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic LEGACY_COMPAT_MODE,
	input wire logic AUTO_DETACH_OPTION,
	output logic [csu_pkg::NUM_CLUSTER:1] DEADLOCK_SEEN,
	csu_if.unit LINK
);
	import csu_pkg::*;

	logic [SEM_COUNT-1:0] sema_reg [1:NUM_CLUSTER];
	logic [CLN_W-1:0] cln_reg [NUM_CPU];
	logic [NUM_CLUSTER:1] attach_reg [NUM_CPU];
	logic [NUM_CPU-1:0] user_reg;
	logic [NUM_CPU-1:0] pend_reg;
	logic [CLN_W-1:0] pend_cl_reg [NUM_CPU];
	logic [SEM_W-1:0] pend_idx_reg [NUM_CPU];
	logic [DL_W-1:0] dl_cnt_reg [1:NUM_CLUSTER];
	logic [NUM_CLUSTER:1] dl_fire;
	logic [NUM_CLUSTER:1] tas_change;
	logic [NUM_CLUSTER:1] all_hold;
	logic rsp_valid_reg;
	logic [CPU_W-1:0] rsp_cpu_reg;
	logic rsp_branch_reg;
	logic rsp_hold_reg;
	logic [SEM_COUNT-1:0] rsp_data_reg;
	logic [NUM_CPU-1:0] release_reg;
	logic [NUM_CPU-1:0] deadlock_reg;
	logic [NUM_CLUSTER:1] seen_reg;

	logic take;
	logic [CLN_W-1:0] cur_cln;
	logic cl_ok;
	logic [SEM_W-1:0] idx;
	logic cur_flag;
	logic grant_hit;
	logic [CPU_W-1:0] grant_cpu;
	logic [CLN_W-1:0] grant_cl;

	// flag i sits at word bit 63-i
	function automatic logic [SEM_W-1:0] bitpos(input logic [SEM_W-1:0] i);
		bitpos = 6'h3F - i;
	endfunction : bitpos

	function automatic logic cl_valid(input logic [CLN_W-1:0] c);
		cl_valid = (c != CLN_RESET) && (c <= CLN_W'(NUM_CLUSTER));
	endfunction : cl_valid

	// decode of the command on the channel
	always_comb begin
		cur_cln = cln_reg[LINK.cmd_cpu];
		cl_ok = cl_valid(cur_cln);
		idx = csu_sem_index(LINK.cmd_sel, LINK.cmd_imm, LINK.cmd_areg);
		cur_flag = cl_ok ? sema_reg[cur_cln][bitpos(idx)] : 1'b0;
	end

	// lowest numbered held processor whose flag reads clear wins
	always_comb begin
		grant_hit = 1'b0;
		grant_cpu = '0;
		grant_cl = CLN_RESET;
		for (int k = NUM_CPU - 1; k >= 0; k--) begin
			if (pend_reg[k] && !sema_reg[pend_cl_reg[k]][bitpos(pend_idx_reg[k])]) begin
				grant_hit = 1'b1;
				grant_cpu = CPU_W'(k);
				grant_cl = pend_cl_reg[k];
			end
		end
	end

	// a grant owns the cycle, so commands wait behind it
	assign LINK.cmd_ready = !grant_hit;
	assign take = LINK.cmd_valid && !grant_hit;

	// flag storage updates
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			for (int c = 1; c <= NUM_CLUSTER; c++) begin
				sema_reg[c] <= SEM_RESET;
			end
		end else if (grant_hit) begin
			sema_reg[grant_cl][bitpos(pend_idx_reg[grant_cpu])] <= 1'b1;
		end else if (take && cl_ok) begin
			case (LINK.cmd_op)
				CSU_OP_SET: sema_reg[cur_cln][bitpos(idx)] <= 1'b1;
				CSU_OP_CLR: sema_reg[cur_cln][bitpos(idx)] <= 1'b0;
				CSU_OP_TAS, CSU_OP_TASB: sema_reg[cur_cln][bitpos(idx)] <= 1'b1;
				CSU_OP_WRALL: sema_reg[cur_cln] <= LINK.cmd_data;
				default: ;
			endcase
		end
	end

	// held test-and-set requests
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pend_reg <= '0;
			for (int k = 0; k < NUM_CPU; k++) begin
				pend_cl_reg[k] <= CLN_RESET;
				pend_idx_reg[k] <= '0;
			end
		end else begin
			if (grant_hit) begin
				pend_reg[grant_cpu] <= 1'b0;
			end
			if (take && cl_ok && LINK.cmd_op == CSU_OP_TAS && cur_flag) begin
				pend_reg[LINK.cmd_cpu] <= 1'b1;
				pend_cl_reg[LINK.cmd_cpu] <= cur_cln;
				pend_idx_reg[LINK.cmd_cpu] <= idx;
			end
			for (int k = 0; k < NUM_CPU; k++) begin
				if (pend_reg[k] && dl_fire[pend_cl_reg[k]]) begin
					pend_reg[k] <= 1'b0;
				end
			end
		end
	end

	// cluster numbers, attachments and privilege tracking
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			user_reg <= '0;
			for (int k = 0; k < NUM_CPU; k++) begin
				cln_reg[k] <= CLN_RESET;
				attach_reg[k] <= '0;
			end
		end else if (take) begin
			case (LINK.cmd_op)
				CSU_OP_XCHG: begin
					user_reg[LINK.cmd_cpu] <= LINK.cmd_user;
					if (LINK.cmd_user) begin
						cln_reg[LINK.cmd_cpu] <= LINK.cmd_cln;
						if (LEGACY_COMPAT_MODE && user_reg[LINK.cmd_cpu]) begin
							attach_reg[LINK.cmd_cpu] <= '0;
						end else if (!LEGACY_COMPAT_MODE && AUTO_DETACH_OPTION && !user_reg[LINK.cmd_cpu]) begin
							attach_reg[LINK.cmd_cpu] <= '0;
						end
						if (cl_valid(LINK.cmd_cln)) begin
							attach_reg[LINK.cmd_cpu][LINK.cmd_cln] <= 1'b1;
						end
					end
				end
				CSU_OP_CLN: begin
					cln_reg[LINK.cmd_cpu] <= LINK.cmd_cln;
					if (cl_valid(LINK.cmd_cln)) begin
						attach_reg[LINK.cmd_cpu][LINK.cmd_cln] <= 1'b1;
					end
				end
				CSU_OP_BCD: attach_reg[LINK.cmd_cpu] <= '0;
				default: ;
			endcase
		end
	end

	// per cluster hold condition and flag activity: set, clear, test-and-set, write-all and grants
	always_comb begin
		for (int c = 1; c <= NUM_CLUSTER; c++) begin
			logic any;
			logic all;
			any = 1'b0;
			all = 1'b1;
			for (int k = 0; k < NUM_CPU; k++) begin
				if (attach_reg[k][c]) begin
					any = 1'b1;
					if (!(pend_reg[k] && pend_cl_reg[k] == CLN_W'(c))) begin
						all = 1'b0;
					end
				end
			end
			all_hold[c] = any && all;
			tas_change[c] = (grant_hit && grant_cl == CLN_W'(c)) || (take && cur_cln == CLN_W'(c)
				&& LINK.cmd_op inside {CSU_OP_SET, CSU_OP_CLR, CSU_OP_TAS, CSU_OP_TASB, CSU_OP_WRALL});
			dl_fire[c] = all_hold[c] && !tas_change[c] && dl_cnt_reg[c] == DL_LAST;
		end
	end

	// deadlock counters
	always_ff @(posedge CORE_CLK) begin
		for (int c = 1; c <= NUM_CLUSTER; c++) begin
			if (RST || tas_change[c] || !all_hold[c] || dl_fire[c]) begin
				dl_cnt_reg[c] <= '0;
			end else begin
				dl_cnt_reg[c] <= dl_cnt_reg[c] + 8'h01;
			end
		end
	end

	// deadlock notice to every processor that was held there
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			deadlock_reg <= '0;
			seen_reg <= '0;
		end else begin
			for (int k = 0; k < NUM_CPU; k++) begin
				deadlock_reg[k] <= pend_reg[k] && dl_fire[pend_cl_reg[k]];
			end
			seen_reg <= seen_reg | dl_fire;
		end
	end

	// answers and release pulses
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rsp_valid_reg <= 1'b0;
			rsp_cpu_reg <= '0;
			rsp_branch_reg <= 1'b0;
			rsp_hold_reg <= 1'b0;
			rsp_data_reg <= SEM_RESET;
			release_reg <= '0;
		end else begin
			release_reg <= '0;
			if (grant_hit) begin
				release_reg[grant_cpu] <= 1'b1;
			end
			rsp_valid_reg <= take;
			if (take) begin
				rsp_cpu_reg <= LINK.cmd_cpu;
				rsp_branch_reg <= LINK.cmd_op == CSU_OP_TASB && cur_flag;
				rsp_hold_reg <= LINK.cmd_op == CSU_OP_TAS && cur_flag;
				rsp_data_reg <= (LINK.cmd_op == CSU_OP_RDALL && cl_ok) ? sema_reg[cur_cln] : SEM_RESET;
			end
		end
	end

	assign LINK.rsp_valid = rsp_valid_reg;
	assign LINK.rsp_cpu = rsp_cpu_reg;
	assign LINK.rsp_branch = rsp_branch_reg;
	assign LINK.rsp_hold = rsp_hold_reg;
	assign LINK.rsp_data = rsp_data_reg;
	assign LINK.release_cpu = release_reg;
	assign LINK.deadlock_cpu = deadlock_reg;
	assign DEADLOCK_SEEN = seen_reg;
endmodule : csu_unit

/* hw/csu_core.sv */
// processor side: issue hold, answer capture and deadlock exchange
`timescale 1ns/100ps
module csu_core (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic USR_VALID,
	output logic USR_READY,
	input wire logic [csu_pkg::CPU_W-1:0] USR_CPU,
	input wire csu_pkg::csu_op_t USR_OP,
	input wire logic USR_SEL,
	input wire logic [csu_pkg::IMM_W-1:0] USR_IMM,
	input wire logic [csu_pkg::IMM_W-1:0] USR_AREG,
	input wire logic [csu_pkg::CLN_W-1:0] USR_CLN,
	input wire logic USR_USER,
	input wire logic [csu_pkg::SEM_COUNT-1:0] USR_DATA,
	input wire logic [csu_pkg::NUM_CPU-1:0] DEADLOCK_IRQ_MODE,
	input wire logic [csu_pkg::NUM_CPU-1:0] GLOBAL_IRQ_ENABLE,
	output logic RSP_VALID,
	output logic [csu_pkg::CPU_W-1:0] RSP_CPU,
	output logic RSP_BRANCH,
	output logic [csu_pkg::SEM_COUNT-1:0] RSP_DATA,
	output logic [csu_pkg::NUM_CPU-1:0] HOLDING,
	output logic [csu_pkg::NUM_CPU-1:0] EXCHANGE_REQ,
	csu_if.core LINK
);
	import csu_pkg::*;

	logic [NUM_CPU-1:0] hold_reg;
	logic rsp_valid_reg;
	logic [CPU_W-1:0] rsp_cpu_reg;
	logic rsp_branch_reg;
	logic [SEM_COUNT-1:0] rsp_data_reg;
	logic [NUM_CPU-1:0] xchg_reg;
	logic blocked;

	// a held processor issues nothing until released or cancelled by a deadlock notice
	assign blocked = hold_reg[USR_CPU] || (LINK.rsp_valid && LINK.rsp_hold && LINK.rsp_cpu == USR_CPU);
	assign LINK.cmd_valid = USR_VALID && !blocked;
	assign USR_READY = LINK.cmd_ready && !blocked;
	assign LINK.cmd_cpu = USR_CPU;
	assign LINK.cmd_op = USR_OP;
	assign LINK.cmd_sel = USR_SEL;
	assign LINK.cmd_imm = USR_IMM;
	assign LINK.cmd_areg = USR_AREG;
	assign LINK.cmd_cln = USR_CLN;
	assign LINK.cmd_user = USR_USER;
	assign LINK.cmd_data = USR_DATA;

	// hold state per processor
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			hold_reg <= '0;
		end else begin
			for (int k = 0; k < NUM_CPU; k++) begin
				if (LINK.release_cpu[k] || LINK.deadlock_cpu[k]) begin
					hold_reg[k] <= 1'b0;
				end else if (LINK.rsp_valid && LINK.rsp_hold && LINK.rsp_cpu == CPU_W'(k)) begin
					hold_reg[k] <= 1'b1;
				end
			end
		end
	end

	// captured answers and deadlock exchange requests
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rsp_valid_reg <= 1'b0;
			rsp_cpu_reg <= '0;
			rsp_branch_reg <= 1'b0;
			rsp_data_reg <= SEM_RESET;
			xchg_reg <= '0;
		end else begin
			rsp_valid_reg <= LINK.rsp_valid && !LINK.rsp_hold;
			rsp_cpu_reg <= LINK.rsp_cpu;
			rsp_branch_reg <= LINK.rsp_branch;
			rsp_data_reg <= LINK.rsp_data;
			xchg_reg <= LINK.deadlock_cpu & DEADLOCK_IRQ_MODE & GLOBAL_IRQ_ENABLE;
		end
	end

	assign RSP_VALID = rsp_valid_reg;
	assign RSP_CPU = rsp_cpu_reg;
	assign RSP_BRANCH = rsp_branch_reg;
	assign RSP_DATA = rsp_data_reg;
	assign HOLDING = hold_reg;
	assign EXCHANGE_REQ = xchg_reg;
endmodule : csu_core

/* verification/csu_props.sv */
// concurrent checks on the channel between the core end and the unit end
`timescale 1ns/100ps
module csu_props (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [csu_pkg::CPU_W-1:0] cmd_cpu,
	input wire csu_pkg::csu_op_t cmd_op,
	input wire logic rsp_valid,
	input wire logic [csu_pkg::CPU_W-1:0] rsp_cpu,
	input wire logic rsp_branch,
	input wire logic rsp_hold,
	input wire logic [csu_pkg::NUM_CPU-1:0] release_cpu,
	input wire logic [csu_pkg::NUM_CPU-1:0] deadlock_cpu
);
	import csu_pkg::*;
	logic take;
	logic [8:0] age_reg [NUM_CPU];
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	assign take = cmd_valid && cmd_ready;
	// cycles since each cpu was last told to hold, saturating
	always_ff @(posedge CORE_CLK) begin
		for (int i = 0; i < NUM_CPU; i++) begin
			if (RST || (rsp_valid && rsp_hold && rsp_cpu == CPU_W'(i))) begin
				age_reg[i] <= 9'h000;
			end else if (age_reg[i] != 9'h1FF) begin
				age_reg[i] <= age_reg[i] + 9'h001;
			end
		end
	end
	// answers follow takes by exactly one cycle
	AST_ANSWER_NEXT: assert property (take |=> rsp_valid)
		else $error("no answer after take");
	AST_ANSWER_CAUSE: assert property (rsp_valid |-> $past(take))
		else $error("answer without take");
	AST_ANSWER_CPU: assert property (take |=> rsp_cpu == $past(cmd_cpu))
		else $error("answer names wrong cpu");
	AST_HOLD_ONLY_TAS: assert property (rsp_valid && rsp_hold |-> $past(cmd_op) == CSU_OP_TAS)
		else $error("hold on other command");
	AST_BRANCH_TASB: assert property (rsp_valid && rsp_branch |-> $past(cmd_op) == CSU_OP_TASB && !rsp_hold)
		else $error("branch on other command");
	AST_GRANT_STEALS: assert property (|release_cpu |-> !$past(cmd_ready))
		else $error("release without stolen cycle");
	AST_ONE_GRANT: assert property ($onehot0(release_cpu))
		else $error("several grants at once");
	AST_DEADLOCK_PULSE: assert property (|deadlock_cpu |=> deadlock_cpu == '0)
		else $error("deadlock pulse too long");
	// a deadlock needs every cancelled cpu to have held for the full count
	for (genvar g = 0; g < NUM_CPU; g++) begin : g_age
		AST_DEADLOCK_AGE: assert property (deadlock_cpu[g] |-> age_reg[g] >= 9'h0FF)
			else $error("deadlock declared early");
	end
	cover property (rsp_valid && rsp_hold);
	cover property (|release_cpu);
	cover property (|deadlock_cpu);
endmodule : csu_props

/* verification/cluster_semaphore_unit_tb.sv */
// bench driving the core end, joined to the unit end through the channel
`timescale 1ns/100ps
module cluster_semaphore_unit_tb;
	import csu_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic v = 1'b0;
	logic [CPU_W-1:0] cpu = 2'h0;
	csu_op_t op = CSU_OP_SET;
	logic sel = 1'b0;
	logic [IMM_W-1:0] imm = 5'h00;
	logic [CLN_W-1:0] cluster_number_reg = 5'h00;
	logic usr = 1'b0;
	logic [SEM_COUNT-1:0] dat = 64'h0;
	logic rdy;
	logic rv;
	logic rbr;
	logic [CPU_W-1:0] rcpu;
	logic [SEM_COUNT-1:0] rdat;
	logic [NUM_CPU-1:0] hold;
	logic [NUM_CPU-1:0] xreq;
	logic [NUM_CPU-1:0] xacc = 4'h0;
	logic legacy = 1'b0;
	logic auto_det = 1'b0;
	logic [NUM_CLUSTER:1] dl_seen;
	int n_fail = 0;
	int total_checks = 0;
	csu_if link();
	csu_unit u_csu_unit(.CORE_CLK(clk), .RST(rst), .LEGACY_COMPAT_MODE(legacy), .AUTO_DETACH_OPTION(auto_det),
		.DEADLOCK_SEEN(dl_seen), .LINK(link));
	csu_core u_csu_core(.CORE_CLK(clk), .RST(rst), .USR_VALID(v), .USR_READY(rdy), .USR_CPU(cpu), .USR_OP(op),
		.USR_SEL(sel), .USR_IMM(imm), .USR_AREG(imm), .USR_CLN(cluster_number_reg), .USR_USER(usr), .USR_DATA(dat),
		.DEADLOCK_IRQ_MODE(4'h5), .GLOBAL_IRQ_ENABLE(4'h3), .RSP_VALID(rv), .RSP_CPU(rcpu), .RSP_BRANCH(rbr),
		.RSP_DATA(rdat), .HOLDING(hold), .EXCHANGE_REQ(xreq), .LINK(link));
	csu_props u_csu_props(.CORE_CLK(clk), .RST(rst), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
		.cmd_cpu(link.cmd_cpu), .cmd_op(link.cmd_op), .rsp_valid(link.rsp_valid), .rsp_cpu(link.rsp_cpu),
		.rsp_branch(link.rsp_branch), .rsp_hold(link.rsp_hold), .release_cpu(link.release_cpu),
		.deadlock_cpu(link.deadlock_cpu));
	always #5 clk = ~clk;
	// exchange requests seen per cpu
	always @(posedge clk) xacc <= rst ? 4'h0 : (xacc | xreq);
	// compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// let n edges pass, then step past their updates
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cycles
	// one command from the core side, held until taken, then the answer is waited out
	task automatic issue(input logic [1:0] c, input csu_op_t o, input logic [5:0] f = 6'h00,
			input logic [4:0] n = 5'h00, input logic u = 1'b0, input logic [63:0] d = 64'h0);
		int k;
		@(posedge clk);
		v <= 1'b1;
		cpu <= c;
		op <= o;
		sel <= f[5];
		imm <= f[4:0];
		cluster_number_reg <= n;
		usr <= u;
		dat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 20);
		chk(rdy, 1'b1);
		v <= 1'b0;
		wait_cycles(1);
	endtask : issue
	// from the last command: notice lands 256 edges on, the hold drops one edge after that
	task automatic dl_expect(input logic [3:0] h);
		wait_cycles(255);
		chk(hold, h);
		wait_cycles(1);
		chk(hold, 4'h0);
	endtask : dl_expect
	// report and stop
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// cut a hang short
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		issue(2'h0, CSU_OP_CLN, 6'h00, 5'h01);
		issue(2'h1, CSU_OP_CLN, 6'h00, 5'h01);
		issue(2'h3, CSU_OP_XCHG, 6'h00, 5'h01, 1'b0);
		issue(2'h0, CSU_OP_RDALL);
		chk(rdat, 64'h0);
		issue(2'h0, CSU_OP_WRALL, 6'h00, 5'h00, 1'b0, 64'h8000000000000001);
		issue(2'h3, CSU_OP_WRALL, 6'h00, 5'h00, 1'b0, 64'hFFFFFFFFFFFFFFFF);
		issue(2'h3, CSU_OP_RDALL);
		chk(rdat, 64'h0);
		chk(rcpu, 2'h3);
		issue(2'h1, CSU_OP_RDALL);
		chk(rdat, 64'h8000000000000001);
		issue(2'h1, CSU_OP_SET, 6'h05);
		issue(2'h1, CSU_OP_SET, 6'h21);
		issue(2'h0, CSU_OP_CLR, 6'h00);
		issue(2'h0, CSU_OP_RDALL);
		chk(rdat, 64'h0400000040000001);
		issue(2'h0, CSU_OP_TASB, 6'h21);
		chk(rbr, 1'b1);
		issue(2'h0, CSU_OP_TASB, 6'h02);
		chk(rbr, 1'b0);
		issue(2'h1, CSU_OP_TAS, 6'h07);
		chk(hold, 4'h0);
		issue(2'h0, CSU_OP_TAS, 6'h02);
		chk(hold, 4'h1);
		issue(2'h1, CSU_OP_CLR, 6'h02);
		wait_cycles(2);
		chk(hold, 4'h0);
		issue(2'h1, CSU_OP_RDALL);
		chk(rdat, 64'h2500000040000001);
		chk(rv, 1'b1);
		issue(2'h2, CSU_OP_XCHG, 6'h00, 5'h01, 1'b1);
		issue(2'h0, CSU_OP_TAS, 6'h02);
		issue(2'h1, CSU_OP_TAS, 6'h02);
		issue(2'h2, CSU_OP_CLR, 6'h02);
		wait_cycles(2);
		chk(hold, 4'h2);
		issue(2'h2, CSU_OP_CLR, 6'h02);
		wait_cycles(2);
		chk(hold, 4'h0);
		issue(2'h3, CSU_OP_CLN, 6'h00, 5'h12);
		issue(2'h3, CSU_OP_WRALL, 6'h00, 5'h00, 1'b0, 64'h00000000000000FF);
		issue(2'h3, CSU_OP_RDALL);
		chk(rdat, 64'h00000000000000FF);
		issue(2'h3, CSU_OP_CLN, 6'h00, 5'h13);
		issue(2'h3, CSU_OP_RDALL);
		chk(rdat, 64'h0);
		issue(2'h0, CSU_OP_TAS, 6'h02);
		issue(2'h1, CSU_OP_TAS, 6'h02);
		issue(2'h2, CSU_OP_TAS, 6'h02);
		chk(hold, 4'h7);
		wait_cycles(254);
		chk(dl_seen, 18'h00000);
		wait_cycles(1);
		chk(dl_seen, 18'h00001);
		wait_cycles(2);
		chk(hold, 4'h0);
		chk(xacc, 4'h1);
		// cpu 3 keeps cluster 1 as its number but drops the attachment
		issue(2'h3, CSU_OP_CLN, 6'h00, 5'h01);
		issue(2'h3, CSU_OP_BCD);
		// multi-attach keeps cluster 1 for cpu 2, so no deadlock until it detaches
		issue(2'h2, CSU_OP_XCHG, 6'h00, 5'h12, 1'b1);
		issue(2'h0, CSU_OP_TAS, 6'h02);
		issue(2'h1, CSU_OP_TAS, 6'h02);
		wait_cycles(260);
		chk(hold, 4'h3);
		issue(2'h2, CSU_OP_BCD);
		wait_cycles(100);
		// a broadside load of the same word restarts the count
		issue(2'h3, CSU_OP_WRALL, 6'h00, 5'h00, 1'b0, 64'h2500000040000001);
		dl_expect(4'h3);
		// legacy mode drops the old cluster on a user-to-user exchange
		@(posedge clk);
		legacy <= 1'b1;
		issue(2'h2, CSU_OP_XCHG, 6'h00, 5'h01, 1'b1);
		issue(2'h2, CSU_OP_XCHG, 6'h00, 5'h12, 1'b1);
		issue(2'h0, CSU_OP_TAS, 6'h02);
		issue(2'h1, CSU_OP_TAS, 6'h02);
		dl_expect(4'h3);
		// auto-detach drops the old cluster on a monitor-to-user exchange
		@(posedge clk);
		legacy <= 1'b0;
		auto_det <= 1'b1;
		issue(2'h3, CSU_OP_CLN, 6'h00, 5'h12);
		issue(2'h2, CSU_OP_XCHG, 6'h00, 5'h00, 1'b0);
		issue(2'h2, CSU_OP_XCHG, 6'h00, 5'h01, 1'b1);
		issue(2'h3, CSU_OP_TAS, 6'h3F);
		dl_expect(4'h8);
		chk(dl_seen, 18'h20001);
		end_sim();
	end
endmodule : cluster_semaphore_unit_tb
